// File: hdl/fbs_params.svh
`ifndef FBS_PARAMS_SVH
`define FBS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FBS_ADR_ALIAS 16'h0012
`define FBS_ADR_AL_CTRL 16'h0120
`define FBS_ADR_AL_STAT 16'h0130
`define FBS_ADR_DC_CTRL 16'h0980
`define FBS_ADR_SM_BASE 16'h0800
`define FBS_SM_MASK 16'hFFE0
`define FBS_SM_OFS_START 3'h0
`define FBS_SM_OFS_LEN 3'h2
`define FBS_SM_OFS_EN 3'h4
`define FBS_ADR_MEMORY_MAPPING_UNIT_BASE 16'h0608
`define FBS_MEMORY_MAPPING_UNIT_MASK 16'hFFCF
`define FBS_MEMORY_MAPPING_UNIT_NUM 2'h3

// ----------------------------------------------------------------
// Fixed memory layout
// ----------------------------------------------------------------
`define FBS_MBX_RX_START 16'h1000
`define FBS_MBX_TX_START 16'h1080
`define FBS_MBX_LEN 16'h0080
`define FBS_PD_RX_START 16'h1100
`define FBS_PD_TX_START 16'h1400
`define FBS_PD_MAX_LEN 16'h0100
`define FBS_PD_TX_LEGACY 16'h1358
`define FBS_PD_LEGACY_LEN 16'h00C8
`define FBS_MBX_STAT_ADR 16'h080D

// ----------------------------------------------------------------
// Sync modes and alias scaling
// ----------------------------------------------------------------
`define FBS_DC_FREE 16'h0000
`define FBS_DC_SYNC0 16'h0300
`define FBS_ALIAS_SCALE 16'h0010

// ----------------------------------------------------------------
// Datagram command codes
// ----------------------------------------------------------------
`define FBS_CMD_APRD 8'h01
`define FBS_CMD_APWR 8'h02
`define FBS_CMD_APRW 8'h03
`define FBS_CMD_FPRD 8'h04
`define FBS_CMD_FPWR 8'h05
`define FBS_CMD_FPRW 8'h06
`define FBS_CMD_BRD 8'h07
`define FBS_CMD_BWR 8'h08
`define FBS_CMD_BRW 8'h09
`define FBS_CMD_LRD 8'h0A
`define FBS_CMD_LWR 8'h0B
`define FBS_CMD_LRW 8'h0C

`endif

// File: hdl/fbs_pkg.sv
package fbs_pkg;

  // --------------------------------------------------------------
  // Communication states, one-hot as shown in the status register
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    FBS_INIT = 4'h1,
    FBS_PREOP = 4'h2,
    FBS_SAFEOP = 4'h4,
    FBS_OP = 4'h8
  } fbs_al_t;

  typedef enum logic [2:0] {
    FBS_IDLE = 3'h1,
    FBS_EXEC = 3'h2,
    FBS_PUSH = 3'h4
  } fbs_ph_t;

  // --------------------------------------------------------------
  // Module state records
  // --------------------------------------------------------------
  typedef struct packed {
    fbs_al_t al;
    logic al_err;
    logic [3:0] al_req;
    logic [3:0][15:0] sm_start;
    logic [3:0][15:0] sm_len;
    logic [3:0] sm_en;
    logic [2:0][15:0] memory_mapping_unit_phys;
    logic [15:0] dc_ctrl;
    fbs_ph_t ph;
    logic [7:0] p_cmd;
    logic [15:0] p_addr;
    logic [15:0] p_wdata;
    logic dg_ready;
    logic rsp_valid;
    logic [15:0] rsp_rdata;
    logic rsp_err;
    logic push_valid;
    logic [15:0] push_data;
    logic mbx_active;
    logic pdo_active;
    logic out_valid;
    logic in_valid;
  } fbs_core_st_t;

  typedef struct packed {
    logic v0;
    logic v1;
    logic [15:0] e0;
    logic [15:0] e1;
  } fbs_buf_st_t;

  typedef struct packed {
    logic loaded;
    logic [15:0] alias_val;
  } fbs_alias_st_t;

endpackage : fbs_pkg

// File: hdl/fbs_stream_if.sv
`timescale 1ns/1ns
interface fbs_stream_if;
  logic valid;
  logic ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fbs_stream_if

// File: hdl/fbs_pair_buf.sv
`timescale 1ns/1ns
module fbs_pair_buf
  import fbs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  fbs_stream_if.snk in_s,
  fbs_stream_if.src out_s
);
  fbs_buf_st_t st;
  fbs_buf_st_t next_st;
  logic push;
  logic pop;

  assign in_s.ready = ~st.v1;
  assign out_s.valid = st.v0;
  assign out_s.data = st.e0;
  assign push = in_s.valid & ~st.v1;
  assign pop = out_s.ready & st.v0;

  // ----------------------------------------------------------------
  // Two-entry queue, head in e0
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (pop) begin
      next_st.e0 = st.e1;
      next_st.v0 = st.v1;
      next_st.v1 = 1'b0;
    end
    if (push) begin
      if (!next_st.v0) begin
        next_st.e0 = in_s.data;
        next_st.v0 = 1'b1;
      end else begin
        next_st.e1 = in_s.data;
        next_st.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : fbs_pair_buf

// File: hdl/fbs_alias_load.sv
`timescale 1ns/1ns
`include "fbs_params.svh"
module fbs_alias_load
  import fbs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] alias_high_switch,
  input wire logic [3:0] alias_low_switch,
  output logic [15:0] node_alias_value
);
  fbs_alias_st_t st;
  fbs_alias_st_t next_st;

  assign node_alias_value = st.alias_val;

  // ----------------------------------------------------------------
  // One capture of the switches after reset release
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (!st.loaded) begin
      next_st.loaded = 1'b1;
      next_st.alias_val = 16'(16'(alias_high_switch) * `FBS_ALIAS_SCALE)
        + 16'(alias_low_switch); // [RQ20] [RQ21]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_alias_formula: assert property ( // [RQ21]
    @(posedge core_clk) disable iff (!rstn)
    $rose(st.loaded) |-> st.alias_val ==
      16'(16'($past(alias_high_switch)) * 16'h0010)
      + 16'($past(alias_low_switch)))
    else $error("alias value not high times 16 plus low");

  a_alias_held: assert property ( // [RQ20]
    @(posedge core_clk) disable iff (!rstn)
    st.loaded |=> st.loaded && $stable(st.alias_val))
    else $error("alias changed after power-on load");

endmodule : fbs_alias_load

// File: hdl/fbs_state_ctrl.sv
`timescale 1ns/1ns
`include "fbs_params.svh"
// Function
// [RQ1] INIT refuses mailbox and process data accesses.
// [RQ2] Master sets address, mailbox channels, clocks, then requests PREOP.
// [RQ3] INIT to PREOP accepted only with correct mailbox channel setup.
// [RQ4] PREOP allows mailbox, refuses process data.
// [RQ5] Master sets process channels, mapping units, mappings before SAFEOP.
// [RQ6] PREOP to SAFEOP checks process channels and clock sync mode.
// [RQ7] SAFEOP exchanges data, drops received outputs, inputs stay valid.
// [RQ8] Master sends valid outputs before requesting OP.
// [RQ9] OP gives mailbox and full process data, outputs forwarded.
// [RQ10] State changes only follow master requests.
// [RQ11] Combined read-write datagrams are refused.
// [RQ12] Channel 0: receive mailbox, 128 bytes at 0x1000.
// [RQ13] Channel 1: transmit mailbox, 128 bytes at 0x1080.
// [RQ14] Channel 2: received process data, up to 256 bytes at 0x1100.
// [RQ15] Channel 3: sent process data, up to 256 bytes at 0x1400.
// [RQ16] Older layout, 200 bytes each, channel 3 at 0x1358, also accepted.
// [RQ17] Mapping units 0,1,2 map receive, transmit, mailbox status.
// [RQ18] Master finds slaves by auto-increment, compares identities.
// [RQ19] Master reads aliases by auto-increment to derive topology.
// [RQ20] Alias loaded at power-on into register 0x0012.
// [RQ21] Alias equals high switch times 16 plus low switch.
// [RQ22] Failed transition check keeps the current state.
module fbs_state_ctrl
  import fbs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] alias_high_switch,
  input wire logic [3:0] alias_low_switch,
  input wire logic dg_valid,
  input wire logic [7:0] dg_cmd,
  input wire logic [15:0] dg_addr,
  input wire logic [15:0] dg_wdata,
  output logic dg_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_err,
  input wire logic [15:0] app_in_data,
  output logic app_out_valid,
  output logic [15:0] app_out_data,
  input wire logic app_out_ready,
  output logic mbx_active,
  output logic pdo_active,
  output logic out_data_valid,
  output logic in_data_valid,
  output logic [3:0] comm_state
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_area(input logic [15:0] a,
                                   input logic [15:0] s,
                                   input logic [15:0] l);
    return (a >= s) && ({1'b0, a} < ({1'b0, s} + {1'b0, l}));
  endfunction : in_area

  function automatic logic is_rw(input logic [7:0] c);
    return (c == `FBS_CMD_APRW) || (c == `FBS_CMD_FPRW) ||
           (c == `FBS_CMD_BRW) || (c == `FBS_CMD_LRW);
  endfunction : is_rw

  function automatic logic is_rd(input logic [7:0] c);
    return (c == `FBS_CMD_APRD) || (c == `FBS_CMD_FPRD) ||
           (c == `FBS_CMD_BRD) || (c == `FBS_CMD_LRD);
  endfunction : is_rd

  function automatic logic is_wr(input logic [7:0] c);
    return (c == `FBS_CMD_APWR) || (c == `FBS_CMD_FPWR) ||
           (c == `FBS_CMD_BWR) || (c == `FBS_CMD_LWR);
  endfunction : is_wr

  // ----------------------------------------------------------------
  // State and sub-blocks
  // ----------------------------------------------------------------
  fbs_core_st_t st;
  fbs_core_st_t next_st;
  logic [15:0] node_alias_value;
  logic p_rd;
  logic p_wr;
  logic p_bad;
  logic hit_mbx;
  logic hit_pdrx;
  logic hit_pdtx;
  logic sm_hit;
  logic memory_mapping_unit_hit;
  logic mbx_ok;
  logic pd_new;
  logic pd_old;
  logic fm_ok;
  logic pd_ok;
  logic dc_ok;
  logic [3:0] req;
  logic tr_ok;
  logic ctrl_wr;

  fbs_stream_if buf_in ();
  fbs_stream_if buf_out ();

  fbs_alias_load u_alias (
    .core_clk(core_clk),
    .rstn(rstn),
    .alias_high_switch(alias_high_switch),
    .alias_low_switch(alias_low_switch),
    .node_alias_value(node_alias_value)
  );

  fbs_pair_buf u_buf (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_s(buf_in.snk),
    .out_s(buf_out.src)
  );

  assign buf_in.valid = st.push_valid;
  assign buf_in.data = st.push_data;
  assign buf_out.ready = app_out_ready;
  assign app_out_valid = buf_out.valid;
  assign app_out_data = buf_out.data;

  assign dg_ready = st.dg_ready;
  assign rsp_valid = st.rsp_valid;
  assign rsp_rdata = st.rsp_rdata;
  assign rsp_err = st.rsp_err;
  assign mbx_active = st.mbx_active;
  assign pdo_active = st.pdo_active;
  assign out_data_valid = st.out_valid;
  assign in_data_valid = st.in_valid;
  assign comm_state = st.al;

  // ----------------------------------------------------------------
  // Address decode of the held request
  // ----------------------------------------------------------------
  assign p_rd = is_rd(st.p_cmd);
  assign p_wr = is_wr(st.p_cmd);
  assign p_bad = is_rw(st.p_cmd) || !(p_rd || p_wr); // [RQ11]
  assign hit_mbx = in_area(st.p_addr, `FBS_MBX_RX_START, `FBS_MBX_LEN) ||
                   in_area(st.p_addr, `FBS_MBX_TX_START, `FBS_MBX_LEN);
  assign hit_pdrx = in_area(st.p_addr, st.sm_start[2], st.sm_len[2]);
  assign hit_pdtx = in_area(st.p_addr, st.sm_start[3], st.sm_len[3]);
  assign sm_hit = (st.p_addr & `FBS_SM_MASK) == `FBS_ADR_SM_BASE;
  assign memory_mapping_unit_hit = ((st.p_addr & `FBS_MEMORY_MAPPING_UNIT_MASK) == `FBS_ADR_MEMORY_MAPPING_UNIT_BASE)
                    && (st.p_addr[5:4] < `FBS_MEMORY_MAPPING_UNIT_NUM);
  assign ctrl_wr = (st.ph == FBS_EXEC) && !p_bad && p_wr && !hit_mbx
                   && !hit_pdrx && !hit_pdtx
                   && (st.p_addr == `FBS_ADR_AL_CTRL);

  // ----------------------------------------------------------------
  // Transition checks
  // ----------------------------------------------------------------
  assign mbx_ok = st.sm_en[0] && st.sm_en[1]
    && (st.sm_start[0] == `FBS_MBX_RX_START)
    && (st.sm_len[0] == `FBS_MBX_LEN) // [RQ12]
    && (st.sm_start[1] == `FBS_MBX_TX_START)
    && (st.sm_len[1] == `FBS_MBX_LEN); // [RQ13]
  assign pd_new = (st.sm_start[2] == `FBS_PD_RX_START)
    && (st.sm_len[2] <= `FBS_PD_MAX_LEN) // [RQ14]
    && (st.sm_start[3] == `FBS_PD_TX_START)
    && (st.sm_len[3] <= `FBS_PD_MAX_LEN); // [RQ15]
  assign pd_old = (st.sm_start[2] == `FBS_PD_RX_START)
    && (st.sm_len[2] <= `FBS_PD_LEGACY_LEN)
    && (st.sm_start[3] == `FBS_PD_TX_LEGACY)
    && (st.sm_len[3] <= `FBS_PD_LEGACY_LEN); // [RQ16]
  assign fm_ok = (st.memory_mapping_unit_phys[0] == st.sm_start[2])
    && (st.memory_mapping_unit_phys[1] == st.sm_start[3])
    && (st.memory_mapping_unit_phys[2] == `FBS_MBX_STAT_ADR); // [RQ17]
  assign pd_ok = (pd_new || pd_old) && fm_ok;
  assign dc_ok = (st.dc_ctrl == `FBS_DC_FREE)
                 || (st.dc_ctrl == `FBS_DC_SYNC0);

  assign req = st.p_wdata[3:0];
  assign tr_ok =
    (req == st.al) ? 1'b1 :
    (req == FBS_INIT) ? 1'b1 :
    (req == FBS_PREOP && st.al != FBS_INIT) ? 1'b1 :
    (req == FBS_SAFEOP && st.al == FBS_OP) ? 1'b1 :
    (req == FBS_PREOP) ? mbx_ok : // [RQ3]
    (req == FBS_SAFEOP && st.al == FBS_PREOP) ? (pd_ok && dc_ok) : // [RQ6]
    (req == FBS_OP && st.al == FBS_SAFEOP) ? 1'b1 : 1'b0;

  // ----------------------------------------------------------------
  // Request sequencer and register file
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    case (st.ph)
      FBS_IDLE: begin
        if (dg_valid) begin
          next_st.p_cmd = dg_cmd;
          next_st.p_addr = dg_addr;
          next_st.p_wdata = dg_wdata;
          next_st.dg_ready = 1'b0;
          next_st.ph = FBS_EXEC;
        end
      end
      FBS_EXEC: begin
        next_st.rsp_rdata = 16'h0000;
        next_st.rsp_err = 1'b0;
        next_st.rsp_valid = 1'b1;
        next_st.dg_ready = 1'b1;
        next_st.ph = FBS_IDLE;
        if (p_bad) begin
          next_st.rsp_err = 1'b1; // [RQ11]
        end else if (hit_mbx) begin
          next_st.rsp_err = (st.al == FBS_INIT); // [RQ1] [RQ4]
        end else if (hit_pdrx) begin
          if (!st.pdo_active) begin
            next_st.rsp_err = 1'b1; // [RQ1] [RQ4]
          end else if (p_wr && st.out_valid) begin
            next_st.push_valid = 1'b1; // [RQ9]
            next_st.push_data = st.p_wdata;
            next_st.rsp_valid = 1'b0;
            next_st.dg_ready = 1'b0;
            next_st.ph = FBS_PUSH;
          end
        end else if (hit_pdtx) begin
          if (!st.in_valid) begin
            next_st.rsp_err = 1'b1; // [RQ1] [RQ4]
          end else if (p_rd) begin
            next_st.rsp_rdata = app_in_data; // [RQ7]
          end
        end else if (p_rd) begin
          if (st.p_addr == `FBS_ADR_ALIAS) begin
            next_st.rsp_rdata = node_alias_value; // [RQ19]
          end else if (st.p_addr == `FBS_ADR_AL_CTRL) begin
            next_st.rsp_rdata = {12'h000, st.al_req};
          end else if (st.p_addr == `FBS_ADR_AL_STAT) begin
            next_st.rsp_rdata = {11'h000, st.al_err, st.al};
          end else if (st.p_addr == `FBS_ADR_DC_CTRL) begin
            next_st.rsp_rdata = st.dc_ctrl;
          end else if (sm_hit) begin
            case (st.p_addr[2:0])
              `FBS_SM_OFS_START: begin
                next_st.rsp_rdata = st.sm_start[st.p_addr[4:3]];
              end
              `FBS_SM_OFS_LEN: begin
                next_st.rsp_rdata = st.sm_len[st.p_addr[4:3]];
              end
              `FBS_SM_OFS_EN: begin
                next_st.rsp_rdata = {15'h0000, st.sm_en[st.p_addr[4:3]]};
              end
              default: begin
                next_st.rsp_rdata = 16'h0000;
              end
            endcase
          end else if (memory_mapping_unit_hit) begin
            next_st.rsp_rdata = st.memory_mapping_unit_phys[st.p_addr[5:4]];
          end
        end else begin
          if (st.p_addr == `FBS_ADR_AL_CTRL) begin
            next_st.al_req = req;
            if (tr_ok) begin
              next_st.al = fbs_al_t'(req); // [RQ10]
              next_st.al_err = 1'b0;
            end else begin
              next_st.al_err = 1'b1; // [RQ22]
            end
          end else if (st.p_addr == `FBS_ADR_DC_CTRL) begin
            next_st.dc_ctrl = st.p_wdata;
          end else if (sm_hit) begin
            case (st.p_addr[2:0])
              `FBS_SM_OFS_START: begin
                next_st.sm_start[st.p_addr[4:3]] = st.p_wdata;
              end
              `FBS_SM_OFS_LEN: begin
                next_st.sm_len[st.p_addr[4:3]] = st.p_wdata;
              end
              `FBS_SM_OFS_EN: begin
                next_st.sm_en[st.p_addr[4:3]] = st.p_wdata[0];
              end
              default: begin
                next_st.rsp_err = 1'b0;
              end
            endcase
          end else if (memory_mapping_unit_hit) begin
            next_st.memory_mapping_unit_phys[st.p_addr[5:4]] = st.p_wdata;
          end
        end
      end
      FBS_PUSH: begin
        if (buf_in.ready) begin
          next_st.push_valid = 1'b0;
          next_st.rsp_valid = 1'b1;
          next_st.rsp_err = 1'b0;
          next_st.dg_ready = 1'b1;
          next_st.ph = FBS_IDLE;
        end
      end
      default: begin
        next_st.push_valid = 1'b0;
        next_st.dg_ready = 1'b1;
        next_st.ph = FBS_IDLE;
      end
    endcase
    next_st.mbx_active = (next_st.al != FBS_INIT); // [RQ1] [RQ4]
    next_st.pdo_active = (next_st.al == FBS_SAFEOP)
                         || (next_st.al == FBS_OP); // [RQ4] [RQ7]
    next_st.out_valid = (next_st.al == FBS_OP); // [RQ7] [RQ9]
    next_st.in_valid = next_st.pdo_active; // [RQ7]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.al <= FBS_INIT;
      st.ph <= FBS_IDLE;
      st.dg_ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_init_refuse_mbx: assert property ( // [RQ1]
    @(posedge core_clk) disable iff (!rstn)
    (st.ph == FBS_EXEC && st.al == FBS_INIT && hit_mbx && !p_bad)
    |=> rsp_valid && rsp_err)
    else $error("mailbox access in INIT not refused");

  a_preop_no_pd: assert property ( // [RQ4]
    @(posedge core_clk) disable iff (!rstn)
    (st.ph == FBS_EXEC && st.al == FBS_PREOP && !p_bad
     && !hit_mbx && hit_pdrx)
    |=> rsp_valid && rsp_err && !st.push_valid)
    else $error("process data accepted in PREOP");

  a_safeop_drop_out: assert property ( // [RQ7]
    @(posedge core_clk) disable iff (!rstn)
    (st.ph == FBS_EXEC && st.al == FBS_SAFEOP && p_wr && !hit_mbx
     && hit_pdrx)
    |=> rsp_valid && !rsp_err && !st.push_valid)
    else $error("output data forwarded in SAFEOP");

  a_op_forward: assert property ( // [RQ9]
    @(posedge core_clk) disable iff (!rstn)
    (st.ph == FBS_EXEC && st.al == FBS_OP && p_wr && !hit_mbx
     && hit_pdrx)
    |=> st.push_valid && st.push_data == $past(st.p_wdata)
        && !rsp_valid)
    else $error("output data not forwarded in OP");

  a_rw_refused: assert property ( // [RQ11]
    @(posedge core_clk) disable iff (!rstn)
    (dg_valid && dg_ready && is_rw(dg_cmd))
    |=> ##1 rsp_valid && rsp_err)
    else $error("combined read-write datagram not refused");

  a_mbx_gate: assert property ( // [RQ3]
    @(posedge core_clk) disable iff (!rstn)
    (ctrl_wr && st.al == FBS_INIT && req == FBS_PREOP && !mbx_ok)
    |=> st.al == FBS_INIT && st.al_err)
    else $error("PREOP entered with bad mailbox setup");

  a_pd_gate: assert property ( // [RQ6]
    @(posedge core_clk) disable iff (!rstn)
    (ctrl_wr && st.al == FBS_PREOP && req == FBS_SAFEOP
     && !(pd_ok && dc_ok))
    |=> st.al == FBS_PREOP && st.al_err)
    else $error("SAFEOP entered with bad process setup");

  a_stay_on_fail: assert property ( // [RQ22]
    @(posedge core_clk) disable iff (!rstn)
    (ctrl_wr && !tr_ok) |=> $stable(st.al) ##1 $stable(st.al))
    else $error("state moved after failed check");

  a_master_driven: assert property ( // [RQ10]
    @(posedge core_clk) disable iff (!rstn)
    (st.al != $past(st.al)) |-> $past(ctrl_wr) && st.al == $past(req))
    else $error("state changed without master request");

endmodule : fbs_state_ctrl

// File: sim/fbs_master_model.sv
`timescale 1ns/1ns
module fbs_master_model
  import fbs_pkg::*;
(
  input wire logic core_clk,
  output logic dg_valid,
  output logic [7:0] dg_cmd,
  output logic [15:0] dg_addr,
  output logic [15:0] dg_wdata,
  input wire logic dg_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic rsp_err
);
  int stuck = 0;
  initial begin
    dg_valid = 1'b0;
    dg_cmd = 8'h00;
    dg_addr = 16'h0000;
    dg_wdata = 16'h0000;
  end
  // ----------------------------------------------------------------
  // One request, held until taken; lines inverted once released
  // ----------------------------------------------------------------
  task automatic xfer(input logic [7:0] c, input logic [15:0] a,
      input logic [15:0] w, output logic [15:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge core_clk);
    dg_valid <= 1'b1;
    dg_cmd <= c;
    dg_addr <= a;
    dg_wdata <= w;
    do @(negedge core_clk); while (dg_ready !== 1'b1 && ++n < 500);
    @(posedge core_clk);
    dg_valid <= 1'b0;
    dg_cmd <= ~c;
    dg_addr <= ~a;
    dg_wdata <= ~w;
    do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 500);
    rd = rsp_rdata;
    er = rsp_err;
    if (n >= 500) stuck++;
    @(posedge core_clk);
  endtask : xfer
endmodule : fbs_master_model

// File: sim/fieldbus_slave_state_and_sync_setup_tb.sv
`timescale 1ns/1ns
`include "fbs_params.svh"
module fieldbus_slave_state_and_sync_setup_tb
  import fbs_pkg::*;
;
  logic core_clk, rstn, dg_valid, dg_ready, rsp_valid, rsp_err;
  logic app_out_valid, app_out_ready, mbx_active, pdo_active;
  logic out_data_valid, in_data_valid, rerr;
  logic [3:0] sw_hi, sw_lo, comm_state;
  logic [7:0] dg_cmd;
  logic [15:0] dg_addr, dg_wdata, rsp_rdata, app_in_data, app_out_data;
  logic [15:0] rdat, q[$];
  logic [7:0] rwc[4] = '{`FBS_CMD_APRW, `FBS_CMD_FPRW, `FBS_CMD_BRW,
    `FBS_CMD_LRW};
  localparam logic [7:0] rd_c = `FBS_CMD_FPRD;
  localparam logic [7:0] wr_c = `FBS_CMD_FPWR;
  localparam logic [15:0] ctl = `FBS_ADR_AL_CTRL;
  localparam logic [15:0] prx = `FBS_PD_RX_START;
  int n_mismatch = 0;
  int checks = 0;
  fbs_master_model M (.core_clk(core_clk), .dg_valid(dg_valid),
    .dg_cmd(dg_cmd), .dg_addr(dg_addr), .dg_wdata(dg_wdata),
    .dg_ready(dg_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_err(rsp_err));
  fbs_state_ctrl DUT (.core_clk(core_clk), .rstn(rstn),
    .alias_high_switch(sw_hi), .alias_low_switch(sw_lo),
    .dg_valid(dg_valid), .dg_cmd(dg_cmd), .dg_addr(dg_addr),
    .dg_wdata(dg_wdata), .dg_ready(dg_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .app_in_data(app_in_data),
    .app_out_valid(app_out_valid), .app_out_data(app_out_data),
    .app_out_ready(app_out_ready), .mbx_active(mbx_active),
    .pdo_active(pdo_active), .out_data_valid(out_data_valid),
    .in_data_valid(in_data_valid), .comm_state(comm_state));
  // ----------------------------------------------------------------
  // Clock, consumer of output words, helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (app_out_valid === 1'b1 && app_out_ready === 1'b1) q.push_back(app_out_data);
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic op(logic [7:0] c, logic [15:0] a, logic [15:0] w);
    M.xfer(c, a, w, rdat, rerr);
  endtask : op
  task automatic st(logic [15:0] e);
    op(rd_c, `FBS_ADR_AL_STAT, 16'h0000);
    chk("al_status", e, {11'h000, rdat[4:0]});
    chk("comm_state", {12'h000, e[3:0]}, {12'h000, comm_state});
  endtask : st
  task automatic sm(int n, logic [15:0] s, logic [15:0] l);
    op(wr_c, `FBS_ADR_SM_BASE + 16'(8 * n), s);
    op(wr_c, `FBS_ADR_SM_BASE + 16'(8 * n + 2), l);
    op(wr_c, `FBS_ADR_SM_BASE + 16'(8 * n + 4), 16'h0001);
  endtask : sm
  task automatic fm(int n, logic [15:0] s);
    op(wr_c, `FBS_ADR_MEMORY_MAPPING_UNIT_BASE + 16'(16 * n), s);
  endtask : fm
  task automatic close_out;
    if (M.stuck != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    close_out;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    sw_hi = 4'hA;
    sw_lo = 4'h5;
    app_in_data = 16'h3C5A;
    app_out_ready = 1'b0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    op(`FBS_CMD_APRD, `FBS_ADR_ALIAS, 16'h0000);
    chk("alias", 16'h00A5, rdat);
    sm(2, prx, `FBS_PD_MAX_LEN);
    sm(3, `FBS_PD_TX_START, `FBS_PD_MAX_LEN);
    op(rd_c, `FBS_MBX_RX_START, 16'h0000);
    chk("init_mbx_err", 16'h0001, {15'h0000, rerr});
    op(rd_c, `FBS_PD_TX_START, 16'h0000);
    chk("init_pd_err", 16'h0001, {15'h0000, rerr});
    foreach (rwc[i]) begin
      op(rwc[i], `FBS_ADR_ALIAS, 16'h0000);
      chk("rw_cmd_err", 16'h0001, {15'h0000, rerr});
    end
    op(wr_c, ctl, 16'h0002);
    st(16'h0011);
    sm(0, `FBS_MBX_RX_START, `FBS_MBX_LEN);
    sm(1, `FBS_MBX_TX_START, `FBS_MBX_LEN);
    op(wr_c, `FBS_ADR_DC_CTRL, `FBS_DC_SYNC0);
    op(wr_c, ctl, 16'h0002);
    st(16'h0002);
    chk("preop_flags", 16'h0002, {14'h0000, mbx_active, pdo_active});
    op(rd_c, `FBS_MBX_TX_START, 16'h0000);
    chk("preop_mbx_err", 16'h0000, {15'h0000, rerr});
    op(rd_c, prx, 16'h0000);
    chk("preop_pd_err", 16'h0001, {15'h0000, rerr});
    op(wr_c, ctl, 16'h0008);
    st(16'h0012);
    fm(0, prx);
    fm(1, `FBS_PD_TX_START);
    op(wr_c, ctl, 16'h0004);
    st(16'h0012);
    fm(2, `FBS_MBX_STAT_ADR);
    op(wr_c, ctl, 16'h0004);
    st(16'h0004);
    chk("safeop_flags", 16'h0006,
      {13'h0000, pdo_active, in_data_valid, out_data_valid});
    op(rd_c, `FBS_PD_TX_START, 16'h0000);
    chk("safeop_in", 16'h3C5A, rdat);
    op(wr_c, prx, 16'h1111);
    chk("safeop_wr_err", 16'h0000, {15'h0000, rerr});
    op(wr_c, ctl, 16'h0008);
    st(16'h0008);
    chk("op_out_valid", 16'h0001, {15'h0000, out_data_valid});
    op(wr_c, prx, 16'hA001);
    op(wr_c, prx + 16'h0002, 16'hA002);
    fork
      op(wr_c, prx + 16'h0004, 16'hA003);
      begin
        repeat (8) @(negedge core_clk);
        chk("stall_ready", 16'h0000, {15'h0000, dg_ready});
        @(posedge core_clk);
        app_out_ready <= 1'b1;
      end
    join
    repeat (4) @(posedge core_clk);
    chk("out_count", 16'h0003, 16'(q.size()));
    foreach (q[i]) chk("out_word", 16'hA001 + 16'(i), q[i]);
    op(wr_c, ctl, 16'h0002);
    st(16'h0002);
    sm(2, prx, `FBS_PD_LEGACY_LEN);
    sm(3, `FBS_PD_TX_LEGACY, `FBS_PD_LEGACY_LEN);
    fm(1, `FBS_PD_TX_LEGACY);
    op(wr_c, ctl, 16'h0004);
    st(16'h0004);
    close_out;
  end
endmodule : fieldbus_slave_state_and_sync_setup_tb
